// file: throttle_pkg.sv
// throttle_pkg: register map, field positions, reset values and timing
// counts for the activity clock throttle.
// assumes a 250 MHz pclk and an apb register port with 32-bit data.
`default_nettype none
package throttle_pkg;
    // register indices; not all are multiples of four, so byte addr = 4*index
    localparam logic [7:0] IDX_IDLE_STEP = 8'hE0;
    localparam logic [7:0] IDX_BUSY_STEP = 8'hE1;
    localparam logic [7:0] IDX_LEVEL = 8'hE2;
    localparam logic [7:0] IDX_CONTROL = 8'hE3;
    localparam logic [7:0] IDX_MASK = 8'hDF;
    localparam logic [7:0] IDX_STATUS = 8'hE5;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_IDLE_STEP = {2'h0, IDX_IDLE_STEP, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_BUSY_STEP = {2'h0, IDX_BUSY_STEP, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_LEVEL = {2'h0, IDX_LEVEL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_MASK = {2'h0, IDX_MASK, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};

    // mask register bit positions
    localparam int MB_CHIP_SELECT = 0;
    localparam int MB_KEYBOARD = 1;
    localparam int MB_CARD = 2;
    localparam int MB_SERIAL = 3;
    localparam int MB_INTERRUPT = 4;
    localparam int MB_DISK = 5;
    localparam int MB_VIDEO = 6;
    localparam int MB_IO_WINDOW = 7;
    localparam int NUM_SOURCES = 8;

    // control register fields
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_RATE_LSB = 0;
    localparam int RATE_W = 3;

    // reset values
    localparam logic [7:0] MASK_RESET = 8'hEF;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] STEP_RESET = 8'h00;
    localparam logic [7:0] LEVEL_RESET = 8'hFF;
    localparam logic [7:0] LEVEL_MIN = 8'h00;
    localparam logic [7:0] LEVEL_MAX = 8'hFF;

    // decoded address windows
    localparam logic [19:0] VID_CGA_LO = 20'hB8000;
    localparam logic [19:0] VID_CGA_HI = 20'hBFFFF;
    localparam logic [19:0] VID_VGA_LO = 20'hA0000;
    localparam logic [19:0] VID_VGA_HI = 20'hAFFFF;
    localparam logic [15:0] DISK_A_LO = 16'h01F0;
    localparam logic [15:0] DISK_A_HI = 16'h01F7;
    localparam logic [15:0] DISK_B_LO = 16'h03F6;
    localparam logic [15:0] DISK_B_HI = 16'h03F7;
    localparam logic [15:0] SER_A = 16'h02E8;
    localparam logic [15:0] SER_B = 16'h02F8;
    localparam logic [15:0] SER_C = 16'h03E8;
    localparam logic [15:0] SER_D = 16'h03F8;
    localparam logic [15:0] SER_WIN_MASK = 16'hFFF8;
    localparam logic [15:0] KBD_PORT = 16'h0060;

    // base sampling period and its cycle count; codes double it
    localparam int CLK_MHZ = 250;
    localparam int BASE_PERIOD_NS = 61035;
    localparam int BASE_PERIOD_CYC = (BASE_PERIOD_NS * CLK_MHZ) / 1000;
    localparam int PERIOD_CNT_W = 24;
endpackage : throttle_pkg
`default_nettype wire

// file: sample_timer.sv
// sample_timer: emits a one-cycle tick at the end of each sampling period.
// assumes the base period count is passed in; codes double the period.
`default_nettype none
module sample_timer #(
    parameter int BASE_CYC = throttle_pkg::BASE_PERIOD_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [throttle_pkg::RATE_W-1:0] rate_sel,
    output logic tick
);
    import throttle_pkg::*;

    logic [PERIOD_CNT_W-1:0] count_reg;
    logic [PERIOD_CNT_W-1:0] count_next;
    logic [PERIOD_CNT_W-1:0] limit;
    wire at_limit;

    // period doubles per code step: 61 us up to 7.81 ms
    assign limit = PERIOD_CNT_W'(BASE_CYC) << rate_sel; // see (R14)
    assign at_limit = (count_reg >= limit - PERIOD_CNT_W'(1));
    assign count_next = (!run || at_limit) ? '0 : count_reg + 1'b1;
    assign tick = run && at_limit;

    // counter frozen at zero while paused so a restart gives a full period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule : sample_timer
`default_nettype wire

// file: level_step.sv
// level_step: computes the next activity level for one sampling period.
// purely combinational; the caller holds the level register.
`default_nettype none
module level_step (
    input wire logic [7:0] level,
    input wire logic active,
    input wire logic [7:0] busy_step,
    input wire logic [7:0] idle_step,
    output logic [7:0] level_out
);
    import throttle_pkg::*;

    wire signed [9:0] delta;
    wire signed [9:0] sum;

    // busy step unsigned, idle step two's complement
    assign delta = active ? $signed({2'b00, busy_step}) // see (R9)
                          : $signed({{2{idle_step[7]}}, idle_step}); // see (R8) (R16)
    assign sum = $signed({2'b00, level}) + delta;
    // clamp so no step wraps past either end
    assign level_out = sum < 0 ? LEVEL_MIN // see (R17)
                     : (sum > 10'sd255 ? LEVEL_MAX : sum[7:0]);
endmodule : level_step
`default_nettype wire

// file: activity_clock_throttle.sv
// activity_clock_throttle: activity-driven processor clock throttle with
// apb registers, source decode, sampling timer and hysteresis request.
// assumes bus cycle decode strobes are synchronous one-cycle pulses.
// Functional notes
// (R1) Unmasked display buffer memory writes count as activity; mask resets 1.
// (R2) Unmasked disk port accesses 1F0-1F7H, 3F6-3F7H count; mask resets 1.
// (R3) Unmasked selected interrupt line activity counts; mask resets 0.
// (R4) Unmasked serial port window accesses count; mask resets 1.
// (R5) Unmasked card controller or card accesses count; mask resets 1.
// (R6) Unmasked keyboard port 060H accesses count; mask resets 1.
// (R7) Unmasked programmable chip select activity counts; mask resets 1.
// (R8) Idle step is signed eight-bit, resets to zero.
// (R9) Active periods add the unsigned busy step to the level.
// (R10) Eight-bit activity level register resets to FFH.
// (R11) Request raised at level 00H, held until level reaches FFH.
// (R12) Software pauses sampling before writing level, then re-enables.
// (R13) Control bit 7 enables sampling; resets to zero.
// (R14) Three-bit rate code picks 61 us up to 7.81 ms period.
// (R15) Unmasked programmed I/O range accesses count; mask resets 1.
// (R16) Idle periods add the signed idle step to the level.
// (R17) Level arithmetic saturates at 00H and FFH.
//
// Register access over APB is this design's own decision.
`default_nettype none
module activity_clock_throttle (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [throttle_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mem_write,
    input wire logic io_access,
    input wire logic [19:0] bus_addr,
    input wire logic vga_mode,
    input wire logic irq_activity,
    input wire logic card_activity,
    input wire logic chip_select_activity,
    input wire logic io_window_hit,
    output logic slow_clock_req
);
    import throttle_pkg::*;

    typedef enum logic {REQ_IDLE, REQ_ACTIVE} req_state_t;

    logic [7:0] mask_reg;
    logic [7:0] idle_step_reg;
    logic [7:0] busy_step_reg;
    logic [7:0] level_reg;
    logic [7:0] level_next;
    logic [7:0] control_reg;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic seen_reg;
    logic seen_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    req_state_t req_reg;
    req_state_t req_next;

    wire enable;
    wire [RATE_W-1:0] rate_sel;
    wire tick;
    wire [7:0] stepped;
    wire [15:0] io_addr;
    wire [NUM_SOURCES-1:0] raw_hit;
    wire [NUM_SOURCES-1:0] live_hit;
    wire any_live;
    wire vid_hit;
    wire disk_hit;
    wire serial_hit;
    wire kbd_hit;

    // apb access phase decode
    wire access;
    wire wr_en;
    wire rd_en;
    wire rd_setup;
    wire hit_mask;
    wire hit_idle;
    wire hit_busy;
    wire hit_level;
    wire hit_ctl;
    wire hit_status;
    wire mapped;

    assign access = psel && penable;
    assign wr_en = access && pwrite;
    assign rd_en = access && !pwrite;
    // read setup cycle: address already valid, so read data can load early
    assign rd_setup = psel && !penable && !pwrite;
    assign hit_mask = (paddr == ADDR_MASK);
    assign hit_idle = (paddr == ADDR_IDLE_STEP);
    assign hit_busy = (paddr == ADDR_BUSY_STEP);
    assign hit_level = (paddr == ADDR_LEVEL);
    assign hit_ctl = (paddr == ADDR_CONTROL);
    assign hit_status = (paddr == ADDR_STATUS);
    assign mapped = hit_mask || hit_idle || hit_busy || hit_level ||
                    hit_ctl || hit_status;

    // zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = prdata_reg;

    assign enable = control_reg[CTL_ENABLE_BIT]; // see (R13)
    assign rate_sel = control_reg[CTL_RATE_LSB +: RATE_W];
    assign io_addr = bus_addr[15:0];

    // address window decode for the video, disk, serial and keyboard sources
    assign vid_hit = mem_write && (vga_mode ?
        (bus_addr >= VID_VGA_LO && bus_addr <= VID_VGA_HI) :
        (bus_addr >= VID_CGA_LO && bus_addr <= VID_CGA_HI)); // see (R1)
    assign disk_hit = io_access &&
        ((io_addr >= DISK_A_LO && io_addr <= DISK_A_HI) ||
         (io_addr >= DISK_B_LO && io_addr <= DISK_B_HI)); // see (R2)
    assign serial_hit = io_access &&
        (((io_addr & SER_WIN_MASK) == SER_A) ||
         ((io_addr & SER_WIN_MASK) == SER_B) ||
         ((io_addr & SER_WIN_MASK) == SER_C) ||
         ((io_addr & SER_WIN_MASK) == SER_D)); // see (R4)
    assign kbd_hit = io_access && (io_addr == KBD_PORT); // see (R6)

    // raw source vector in mask bit order
    assign raw_hit[MB_CHIP_SELECT] = chip_select_activity; // see (R7)
    assign raw_hit[MB_KEYBOARD] = kbd_hit;
    assign raw_hit[MB_CARD] = card_activity; // see (R5)
    assign raw_hit[MB_SERIAL] = serial_hit;
    assign raw_hit[MB_INTERRUPT] = irq_activity; // see (R3)
    assign raw_hit[MB_DISK] = disk_hit;
    assign raw_hit[MB_VIDEO] = vid_hit;
    assign raw_hit[MB_IO_WINDOW] = io_access && io_window_hit; // see (R15)

    // a set mask bit removes its source from the throttle
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SOURCES; gi++) begin : g_mask
            assign live_hit[gi] = raw_hit[gi] && !mask_reg[gi]; // see (R1) (R2) (R3) (R4) (R5) (R6) (R7) (R15)
        end
    endgenerate
    assign any_live = |live_hit;

    sample_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .run(enable),
        .rate_sel(rate_sel),
        .tick(tick)
    );

    level_step u_step (
        .level(level_reg),
        .active(seen_reg || any_live),
        .busy_step(busy_step_reg),
        .idle_step(idle_step_reg),
        .level_out(stepped)
    );

    // activity seen this period; a hit in the tick cycle still counts
    assign seen_next = tick ? 1'b0 : (seen_reg || (enable && any_live));

    // level: sampling updates when enabled; software writes only land while
    // paused, otherwise a write could race a sampling tick
    assign level_next = (wr_en && hit_level && !enable) ? pwdata[7:0] // see (R12)
                      : (tick ? stepped : level_reg); // see (R10)

    // sticky raw-activity status, clear on read; only the bits the read
    // reported are cleared, so an event between setup and access survives
    assign status_next = (status_reg &
                          ~((rd_en && hit_status) ? prdata_reg[7:0] : 8'h00)) |
                         raw_hit;

    // hysteresis on the level: assert at floor, release at ceiling
    always_comb begin
        req_next = req_reg;
        unique case (req_reg)
            REQ_IDLE: if (level_reg == LEVEL_MIN) begin
                req_next = REQ_ACTIVE; // see (R11)
            end
            REQ_ACTIVE: if (level_reg == LEVEL_MAX) begin
                req_next = REQ_IDLE; // see (R11)
            end
        endcase
    end
    assign slow_clock_req = (req_reg == REQ_ACTIVE);

    // read mux, loaded at the setup edge so the flopped data already stands
    // in the access phase; this is what makes zero wait states legal
    assign prdata_next = !rd_setup ? prdata_reg :
        hit_mask ? {24'h000000, mask_reg} :
        hit_idle ? {24'h000000, idle_step_reg} :
        hit_busy ? {24'h000000, busy_step_reg} :
        hit_level ? {24'h000000, level_reg} :
        hit_ctl ? {24'h000000, control_reg} :
        hit_status ? {24'h000000, status_reg} : 32'h00000000;

    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= MASK_RESET; // see (R3)
            idle_step_reg <= STEP_RESET; // see (R8)
            busy_step_reg <= STEP_RESET; // see (R9)
            control_reg <= CONTROL_RESET; // see (R13)
        end else if (wr_en) begin
            if (hit_mask) mask_reg <= pwdata[7:0];
            if (hit_idle) idle_step_reg <= pwdata[7:0];
            if (hit_busy) busy_step_reg <= pwdata[7:0];
            if (hit_ctl) control_reg <= {pwdata[7], 4'h0, pwdata[2:0]};
        end
    end

    // block state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_reg <= LEVEL_RESET; // see (R10)
            seen_reg <= 1'b0;
            status_reg <= 8'h00;
            req_reg <= REQ_IDLE;
            prdata_reg <= 32'h00000000;
        end else begin
            level_reg <= level_next;
            seen_reg <= seen_next;
            status_reg <= status_next;
            req_reg <= req_next;
            prdata_reg <= prdata_next;
        end
    end
endmodule : activity_clock_throttle
`default_nettype wire

// file: activity_throttle_checker.sv
// activity_throttle_checker: port assertions for the throttle top.
// assumes one pclk domain and an asynchronous active-low presetn.
`default_nettype none
module activity_throttle_checker
    import throttle_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic slow_clock_req
);
    wire logic acc;
    wire logic rd_acc;
    wire logic rd_setup;
    wire logic mapped;
    // access-phase decode; the status word counts as mapped too
    assign acc = psel && penable;
    assign rd_acc = acc && !pwrite;
    // read data is loaded at the edge that ends the setup cycle
    assign rd_setup = psel && !penable && !pwrite;
    assign mapped = paddr inside {ADDR_IDLE_STEP, ADDR_BUSY_STEP, ADDR_LEVEL,
        ADDR_CONTROL, ADDR_MASK, ADDR_STATUS};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a level read: its setup cycle, then the value shown in the access phase
    sequence read_zero;
        rd_setup && paddr == ADDR_LEVEL
        ##1 rd_acc && prdata[7:0] == LEVEL_MIN;
    endsequence
    sequence read_full;
        rd_setup && paddr == ADDR_LEVEL
        ##1 rd_acc && prdata[7:0] == LEVEL_MAX;
    endsequence
    a_zero_wait: assert property (acc |-> pready)
        else $error("access phase without ready");
    a_err_decode: assert property (acc |-> pslverr == !mapped)
        else $error("error flag disagrees with decode");
    a_err_phase: assert property (pslverr |-> acc)
        else $error("error flag outside access phase");
    a_rdata_hold: assert property (!$past(rd_setup) |-> $stable(prdata))
        else $error("read data moved without a read setup");
    a_hole_zero: assert property (rd_acc && !mapped |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_req_at_zero: assert property (read_zero |-> slow_clock_req)
        else $error("level zero without clock request");
    a_req_at_full: assert property (read_full |-> !slow_clock_req)
        else $error("level full with clock request");
    a_req_held: assert property (
        $rose(slow_clock_req) |=> slow_clock_req [*3])
        else $error("clock request dropped at once");
endmodule : activity_throttle_checker
bind activity_clock_throttle activity_throttle_checker u_chk (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .slow_clock_req);
`default_nettype wire

// file: act_source.sv
// act_source: behavioural cpu bus activity source for the throttle.
// assumes the bench seeds the generator; kbd_on asks for keyboard cycles.
`default_nettype none
module act_source (
    input wire logic pclk,
    input wire logic kbd_on,
    output logic mem_write,
    output logic io_access,
    output logic [19:0] bus_addr,
    output logic vga_mode,
    output logic card_activity,
    output logic chip_select_activity,
    output logic io_window_hit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] n = 4'h0;
    // one-cycle strobes; address scrambles between cycles, never holds
    always @(posedge pclk) begin
        n <= n + 4'h1;
        mem_write <= n == 4'h2; // random address, video masked
        io_access <= n == 4'h6 || n == 4'hE;
        if (n == 4'h6 && kbd_on)
            bus_addr <= 20'h00060;
        else if (n == 4'hE)
            bus_addr <= 20'h08000 | 20'($urandom & 12'hFFF); // no window
        else
            bus_addr <= 20'($urandom);
        vga_mode <= 1'($urandom);
        card_activity <= ($urandom % 5) == 0; // masked
        chip_select_activity <= ($urandom % 7) == 0; // masked
        io_window_hit <= 1'($urandom); // masked
    end
endmodule : act_source
`default_nettype wire

// file: activity_clock_throttle_test.sv
// activity_clock_throttle_test: bench with apb master, activity source
// and integer level model; assumes rate code 000, base period default.
`default_nettype none
module activity_clock_throttle_test;
    timeunit 1ns;
    timeprecision 1ps;
    import throttle_pkg::*;
    localparam int P = BASE_PERIOD_CYC;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, kbd_on = 1'b0, irq_activity = 1'b0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, mem_write, io_access, vga_mode, card_activity;
    logic chip_select_activity, io_window_hit, slow_clock_req, er;
    logic [19:0] bus_addr;
    int mismatches = 0, checks = 0, lvl = 255, req = 0;
    activity_clock_throttle uut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_write, .io_access,
        .bus_addr, .vga_mode, .irq_activity, .card_activity,
        .chip_select_activity, .io_window_hit, .slow_clock_req);
    act_source src (.pclk, .kbd_on, .mem_write, .io_access, .bus_addr,
        .vga_mode, .card_activity, .chip_select_activity, .io_window_hit);
    // 250 MHz clock
    initial forever #2 pclk = ~pclk;
    task automatic results();
        if (mismatches == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one apb transfer; read data and error flag are taken at the edge
    // where pready is seen high, and only then is the request released
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        er = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input string nm, input logic [ADDR_W-1:0] a,
                       input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
        chk("pslverr", {31'h0, ee}, {31'h0, er});
    endtask : rdc
    function automatic int sat(input int v);
        return v < 0 ? 0 : (v > 255 ? 255 : v);
    endfunction : sat
    // one sampling period of the model, then compare level and request
    task automatic period(input int s);
        repeat (P - 4) @(posedge pclk);
        lvl = sat(lvl + s);
        if (lvl == 0)
            req = 1;
        else if (lvl == 255)
            req = 0;
        rdc("level", ADDR_LEVEL, lvl, 1'b0);
        chk("slow_clock_req", req, {31'h0, slow_clock_req});
    endtask : period
    // watchdog: the full run needs about five sampling periods
    initial begin
        repeat (6 * P) @(posedge pclk);
        mismatches++;
        results();
    end
    initial begin
        void'($urandom(32'hE9D0C4E8));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdc("mask", ADDR_MASK, 32'hEF, 1'b0);
        rdc("idle", ADDR_IDLE_STEP, 32'h00, 1'b0);
        rdc("busy", ADDR_BUSY_STEP, 32'h00, 1'b0);
        rdc("level", ADDR_LEVEL, 32'hFF, 1'b0);
        rdc("control", ADDR_CONTROL, 32'h00, 1'b0);
        rdc("unmapped", 12'h000, 32'h00, 1'b1);
        apb(1'b1, ADDR_CONTROL, 32'h07);
        rdc("rate", ADDR_CONTROL, 32'h07, 1'b0);
        apb(1'b1, ADDR_IDLE_STEP, 32'hFF);
        rdc("idle", ADDR_IDLE_STEP, 32'hFF, 1'b0);
        apb(1'b1, ADDR_BUSY_STEP, 32'h80);
        apb(1'b1, ADDR_LEVEL, 32'h02); // paused, so accepted
        rdc("preload", ADDR_LEVEL, 32'h02, 1'b0);
        lvl = 2;
        kbd_on <= 1'b1;
        apb(1'b1, ADDR_CONTROL, 32'h80);
        apb(1'b1, ADDR_LEVEL, 32'h55); // running, so dropped
        repeat (90) @(posedge pclk);
        period(-1); // keyboard masked
        period(-1);
        period(-1);
        @(posedge pclk);
        irq_activity <= 1'b1; // one unmasked interrupt pulse
        @(posedge pclk);
        irq_activity <= 1'b0;
        period(128); // interrupt only, keyboard masked
        apb(1'b1, ADDR_MASK, 32'hED);
        period(128);
        results();
    end
endmodule : activity_clock_throttle_test
`default_nettype wire
